/* File: inc/hlt_pkg.sv */
package hlt_pkg;

  // ********************************
  // Register map (byte addresses)
  // ********************************
  localparam logic [11:0] OFF_TIMER_CONTROL = 12'h000;
  localparam logic [11:0] OFF_MODE          = 12'h004;
  localparam logic [11:0] OFF_PERIOD        = 12'h008;
  localparam logic [11:0] OFF_DUTY_PAIR     = 12'h00C;
  localparam logic [11:0] OFF_CAPTURE_PWM   = 12'h010;
  localparam logic [11:0] OFF_STATUS        = 12'h014;

  // ********************************
  // Field positions
  // ********************************
  localparam int CTRL_ON_BIT    = 7;
  localparam int CTRL_PRE_LSB   = 4;
  localparam int CTRL_POST_LSB  = 0;
  localparam int CPC_EN_BIT     = 7;
  localparam int CPC_FMT_BIT    = 4;
  localparam int STAT_PWM_BIT   = 9;
  localparam int STAT_RUN_BIT   = 8;
  localparam int DUTY_LEFT_LSB  = 6;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0]  RST_TIMER_CONTROL = 8'h00;
  localparam logic [4:0]  RST_MODE          = 5'h00;
  localparam logic [7:0]  RST_PERIOD        = 8'hFF;
  localparam logic [15:0] RST_DUTY_PAIR     = 16'h0000;
  localparam logic [7:0]  RST_CAPTURE_PWM   = 8'h00;

  // ********************************
  // Mode families and timing
  // ********************************
  localparam logic [1:0] FAM_FREE    = 2'h0;
  localparam logic [1:0] FAM_ONESHOT = 2'h1;
  localparam logic [1:0] FAM_MONO    = 2'h2;
  // Timer clock is the system clock divided by four
  localparam int          FOSC_PER_TICK = 4;
  localparam logic [1:0]  PHASE_LAST    = 2'(FOSC_PER_TICK - 1);

  typedef enum logic [0:0] {ST_WAIT, ST_RUN} run_state_t;

endpackage

/* File: rtl/hw_limit_timer_with_pwm.sv */
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps

// How it works
// R1: Free code 000 counts while enable is set, stops when cleared.
// R2: Free codes 001/010 count only while enabled and reset signal high/low.
// R3: Free codes 011-111 reset on any/rise/fall edge, low/high level.
// R4: One-shot code 000 starts as soon as software sets enable.
// R5: One-shot 001/010/011 start on rising, falling or any edge.
// R6: One-shot 100-111 combine edge start with edge or level reset.
// R7: One-shot: clock after count equals period clears enable, count to zero.
// R8: Mono-stable: count stops at zero, enable stays, next edge restarts.
// R9: Level one-shot 110/111 start on high/low, reset on opposite level.
// R10: Edge seen while disabled is ignored; a fresh edge is needed.
// R11: Enable clear holds all counters and state machines in reset.
// R12: Prescaler divides timer clock by 1 to 128 in powers of two.
// R13: Postscaler divides period matches by field value plus one.
// R14: After period match: clear count, set PWM pin, latch duty buffer.
// R15: Zero duty never sets the PWM pin at period start.
// R16: Postscaler never changes PWM period; period is (P+1)*4*prescale.
// R17: Duty pair writable any time; buffer only loads on a match.
// R18: Format bit selects left or right alignment of the duty value.
// R19: Time base is count plus two bits of clock phase or prescaler.
// R20: Time base equal to buffered duty drives PWM low.
// R21: Duty beyond period leaves the PWM pin unchanged.
// R22: Software must pick system clock over four for PWM use.
// R23: Reserved mode codes keep the timer stopped at zero.
// R24: External reset signal is synchronised; edges from successive samples.
module hw_limit_timer_with_pwm #(
  parameter int COUNT_W = 8
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Timer and PWM pins
  input  wire logic                 external_reset_signal,
  output logic                      pwm_output_pin,
  output logic                      postscale_tick
);

  // Time base and registers are built for an 8-bit count only
  if (COUNT_W != 8)
  begin : g_bad_count_w
    $error("COUNT_W must be 8");
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [6:0] pre_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = (8'h01 << sel) - 8'h01;
    return m[6:0];
  endfunction

  function automatic logic [1:0] frac_bits(input logic [8:0] pos,
                                           input logic [2:0] sel);
    logic [8:0] s;
    s = pos >> sel;
    return s[1:0];
  endfunction

  // ********************************
  // Registers
  // ********************************
  logic                on_q;
  logic [2:0]          pre_sel_q;
  logic [3:0]          post_sel_q;
  logic [4:0]          mode_q;
  logic [7:0]          period_q;
  logic [15:0]         duty_pair_q;
  logic                pwm_en_q;
  logic                fmt_q;
  logic [1:0]          phase_q;
  logic [6:0]          pre_q;
  logic [7:0]          count_q;
  logic [3:0]          post_q;
  logic [9:0]          duty_buf_q;
  logic                pwm_q;
  logic                post_tick_q;
  logic                ers_s1_q;
  logic                ers_s2_q;
  logic                ers_prev_q;
  hlt_pkg::run_state_t state_q;
  logic [31:0]         prdata_q;
  logic                pready_q;
  logic                pslverr_q;

  // ********************************
  // APB decode
  // ********************************
  wire access   = psel & penable;
  wire done     = access & pready_q;
  wire wr_en    = done & pwrite;
  wire sel_ctrl = paddr == hlt_pkg::OFF_TIMER_CONTROL;
  wire sel_mode = paddr == hlt_pkg::OFF_MODE;
  wire sel_per  = paddr == hlt_pkg::OFF_PERIOD;
  wire sel_duty = paddr == hlt_pkg::OFF_DUTY_PAIR;
  wire sel_cpc  = paddr == hlt_pkg::OFF_CAPTURE_PWM;
  wire sel_stat = paddr == hlt_pkg::OFF_STATUS;
  wire mapped   = sel_ctrl | sel_mode | sel_per | sel_duty | sel_cpc
                | sel_stat;
  wire wr_ctrl  = wr_en & sel_ctrl & pstrb[0];

  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (sel_ctrl)
      rdata[7:0] = {on_q, pre_sel_q, post_sel_q};
    else if (sel_mode)
      rdata[4:0] = mode_q;
    else if (sel_per)
      rdata[7:0] = period_q;
    else if (sel_duty)
      rdata[15:0] = duty_pair_q;
    else if (sel_cpc)
    begin
      rdata[hlt_pkg::CPC_EN_BIT]  = pwm_en_q;
      rdata[hlt_pkg::CPC_FMT_BIT] = fmt_q;
    end
    else if (sel_stat)
      rdata[9:0] = {pwm_q, state_q == hlt_pkg::ST_RUN, count_q};
  end

  // One wait state, so every answer leaves a flip-flop
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      prdata_q  <= (access & ~pready_q & ~pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // ********************************
  // External reset signal
  // ********************************
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ers_s1_q   <= 1'b0;
      ers_s2_q   <= 1'b0;
      ers_prev_q <= 1'b0;
    end
    else
    begin
      ers_s1_q   <= external_reset_signal;  // see R24
      ers_s2_q   <= ers_s1_q;
      ers_prev_q <= ers_s2_q;
    end
  end

  wire lvl  = ers_s2_q;
  wire rise = ers_s2_q & ~ers_prev_q;  // see R24
  wire fall = ~ers_s2_q & ers_prev_q;

  // ********************************
  // Mode decode
  // ********************************
  wire [1:0] fam  = mode_q[4:3];
  wire [2:0] code = mode_q[2:0];
  wire is_free  = fam == hlt_pkg::FAM_FREE;
  wire lvl_one  = (fam == hlt_pkg::FAM_MONO) & (code[2:1] == 2'h3);
  wire is_one   = (fam == hlt_pkg::FAM_ONESHOT) | lvl_one;
  wire is_mono  = (fam == hlt_pkg::FAM_MONO) & (code != 3'h0)
                & ~code[2];
  wire reserved = ~(is_free | is_one | is_mono);  // see R23

  logic start_ok;
  logic hw_rst;
  logic gate;
  always_comb
  begin
    start_ok = 1'b0;
    hw_rst   = 1'b0;
    gate     = 1'b1;
    if (is_free)
    begin
      start_ok = 1'b1;  // see R1
      case (code)
        3'h1: gate = lvl;  // see R2
        3'h2: gate = ~lvl;
        3'h3: hw_rst = rise | fall;  // see R3
        3'h4: hw_rst = rise;
        3'h5: hw_rst = fall;
        3'h6: begin hw_rst = ~lvl; gate = lvl; end
        3'h7: begin hw_rst = lvl; gate = ~lvl; end
        default: gate = 1'b1;
      endcase
    end
    else if (lvl_one)
    begin
      start_ok = code[0] ? ~lvl : lvl;  // see R9
      hw_rst   = code[0] ? lvl : ~lvl;
    end
    else if (is_one | is_mono)
    begin
      case (code)
        3'h0: start_ok = 1'b1;  // see R4
        3'h1: start_ok = rise;  // see R5
        3'h2: start_ok = fall;
        3'h3: start_ok = rise | fall;
        3'h4: begin start_ok = rise; hw_rst = rise; end  // see R6
        3'h5: begin start_ok = fall; hw_rst = fall; end
        3'h6: begin start_ok = rise; hw_rst = ~lvl; end
        default: begin start_ok = fall; hw_rst = lvl; end
      endcase
    end
  end

  // ********************************
  // Prescaler and timer
  // ********************************
  wire running = (state_q == hlt_pkg::ST_RUN) & on_q & ~reserved;
  wire tick    = (phase_q == hlt_pkg::PHASE_LAST)
               & (pre_q == pre_mask(pre_sel_q));  // see R12
  wire inc     = tick & running & gate;
  wire match   = inc & (count_q == period_q);
  wire [9:0] duty_new = fmt_q
                      ? duty_pair_q[15:hlt_pkg::DUTY_LEFT_LSB]
                      : duty_pair_q[9:0];  // see R18
  wire [1:0] frac = frac_bits({pre_q, phase_q}, pre_sel_q);
  wire [9:0] tbase = {count_q, frac};  // see R19
  wire [1:0] phase_d  = phase_q + 2'h1;
  wire [6:0] pre_d    = (phase_q != hlt_pkg::PHASE_LAST) ? pre_q
                      : tick ? 7'h00 : pre_q + 7'h01;

  always_ff @(posedge sys_clk)
  begin
    if (srst || !on_q)  // see R11
    begin
      phase_q <= 2'h0;
      pre_q   <= 7'h00;
    end
    else
    begin
      phase_q <= phase_d;
      pre_q   <= pre_d;
    end
  end

  logic [7:0] count_d;
  always_comb
  begin
    count_d = count_q;
    if (!on_q || reserved)
      count_d = 8'h00;  // see R23
    else if (hw_rst && (state_q == hlt_pkg::ST_RUN || is_free))
      count_d = 8'h00;  // see R3
    else if (match)
      count_d = 8'h00;  // see R14
    else if (inc)
      count_d = count_q + 8'h01;
  end

  // Base one clock ahead: the pin is a flop, so it must fall as the base
  // reaches the duty value, not a clock later
  wire [9:0] tbase_nx = {count_d, frac_bits({pre_d, phase_d}, pre_sel_q)};

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      count_q <= 8'h00;
      state_q <= hlt_pkg::ST_WAIT;
    end
    else
    begin
      count_q <= count_d;
      if (!on_q || reserved)
        state_q <= hlt_pkg::ST_WAIT;  // see R10
      else if (state_q == hlt_pkg::ST_WAIT && start_ok)
        state_q <= hlt_pkg::ST_RUN;
      else if (match && !is_free)
        state_q <= hlt_pkg::ST_WAIT;  // see R8
    end
  end

  // ********************************
  // Control registers
  // ********************************
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      {on_q, pre_sel_q, post_sel_q} <= hlt_pkg::RST_TIMER_CONTROL;
      mode_q      <= hlt_pkg::RST_MODE;
      period_q    <= hlt_pkg::RST_PERIOD;
      duty_pair_q <= hlt_pkg::RST_DUTY_PAIR;
      pwm_en_q    <= hlt_pkg::RST_CAPTURE_PWM[hlt_pkg::CPC_EN_BIT];
      fmt_q       <= hlt_pkg::RST_CAPTURE_PWM[hlt_pkg::CPC_FMT_BIT];
    end
    else
    begin
      // Software write outranks the hardware clear of the enable
      if (wr_ctrl)
        {on_q, pre_sel_q, post_sel_q} <= pwdata[7:0];
      else if (match && is_one)
        on_q <= 1'b0;  // see R7
      if (wr_en && sel_mode && pstrb[0])
        mode_q <= pwdata[4:0];
      if (wr_en && sel_per && pstrb[0])
        period_q <= pwdata[7:0];
      if (wr_en && sel_duty && pstrb[0])
        duty_pair_q[7:0] <= pwdata[7:0];  // see R17
      if (wr_en && sel_duty && pstrb[1])
        duty_pair_q[15:8] <= pwdata[15:8];
      if (wr_en && sel_cpc && pstrb[0])
      begin
        pwm_en_q <= pwdata[hlt_pkg::CPC_EN_BIT];
        fmt_q    <= pwdata[hlt_pkg::CPC_FMT_BIT];
      end
    end
  end

  // ********************************
  // Postscaler and PWM
  // ********************************
  // Postscaler sits off the PWM path, so it never bends the period
  always_ff @(posedge sys_clk)
  begin
    if (srst || !on_q)
    begin
      post_q      <= 4'h0;
      post_tick_q <= 1'b0;
    end
    else
    begin
      post_tick_q <= match && (post_q == post_sel_q);  // see R13
      if (match)
        post_q <= (post_q == post_sel_q) ? 4'h0 : post_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      duty_buf_q <= 10'h000;
      pwm_q      <= 1'b0;
    end
    else
    begin
      if (match)
        duty_buf_q <= duty_new;  // see R17
      if (!pwm_en_q)
        pwm_q <= 1'b0;
      else if (match)
        pwm_q <= duty_new != 10'h000;  // see R14 see R15 see R16
      else if (on_q && tbase_nx == duty_buf_q)
        pwm_q <= 1'b0;  // see R20 see R21
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign pwm_output_pin = pwm_q;
  assign postscale_tick = post_tick_q;

  // ********************************
  // Checks
  // ********************************
  sequence s_oneshot_end;
    match && is_one && !wr_ctrl;
  endsequence

  sequence s_stopped_at_zero;
    count_q == 8'h00 && state_q == hlt_pkg::ST_WAIT;
  endsequence

  AST_OFF_HOLDS: assert property (!on_q |=> count_q == 8'h00)  // see R11
    else $error("count not held while disabled");
  AST_ONESHOT_END: assert property (
    s_oneshot_end |=> !on_q ##0 s_stopped_at_zero)  // see R7
    else $error("one-shot did not clear enable at match");
  AST_MONO_KEEP: assert property (
    match && is_mono && !wr_ctrl |=> on_q ##0 s_stopped_at_zero)  // see R8
    else $error("mono-stable end wrong");
  AST_RESERVED: assert property (
    reserved |=> count_q == 8'h00)  // see R23
    else $error("reserved mode let the count move");
  AST_PWM_SET: assert property (
    match && pwm_en_q && duty_new != 10'h000
      |=> pwm_q && duty_buf_q == $past(duty_new))  // see R14
    else $error("period match did not set pin and latch duty");
  AST_ZERO_DUTY: assert property (
    match && duty_new == 10'h000 |=> !pwm_q)  // see R15
    else $error("zero duty set the pin");
  AST_DUTY_CLEAR: assert property (
    pwm_en_q && on_q && !match && tbase == duty_buf_q |=> !pwm_q)  // see R20
    else $error("pin not cleared at duty match");
  AST_DUTY_AHEAD: assert property (  // see R20
    pwm_en_q && on_q && !match && tbase_nx == duty_buf_q
      |=> !pwm_q)
    else $error("pin not cleared as base reached duty");
  AST_GATE_HOLD: assert property (
    is_free && code == 3'h1 && !lvl && on_q && !wr_en
      |=> $stable(count_q))  // see R2
    else $error("gated timer counted");
  AST_BUF_HOLD: assert property (!match |=> $stable(duty_buf_q))  // see R17
    else $error("duty buffer moved without a match");

endmodule  // hw_limit_timer_with_pwm

/* File: sim/hw_limit_timer_with_pwm_test.sv */
`timescale 1ns/1ps

module hw_limit_timer_with_pwm_test;

  // ****************
  // Signals
  // ****************
  localparam logic [11:0] A_TC = hlt_pkg::OFF_TIMER_CONTROL;
  localparam logic [11:0] A_MD = hlt_pkg::OFF_MODE;
  localparam logic [11:0] A_PR = hlt_pkg::OFF_PERIOD;
  localparam logic [11:0] A_DU = hlt_pkg::OFF_DUTY_PAIR;
  localparam logic [11:0] A_CP = hlt_pkg::OFF_CAPTURE_PWM;
  localparam logic [11:0] A_ST = hlt_pkg::OFF_STATUS;

  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        external_reset_signal = 1'b0;
  logic        pwm_output_pin;
  logic        postscale_tick;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  int          t0;

  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
    cyc <= cyc + 1;

  hw_limit_timer_with_pwm #(
    .COUNT_W (8)
  ) u_dut (
    .sys_clk               (sys_clk),
    .srst                  (srst),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pstrb                 (pstrb),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .external_reset_signal (external_reset_signal),
    .pwm_output_pin        (pwm_output_pin),
    .postscale_tick        (postscale_tick)
  );

  // ****************
  // Checks and bus tasks
  // ****************
  task automatic fail(input string msg);
    bad_count++;
    $display("ERROR %0t: %s", $time, msg);
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
      $display("ERROR %0t: word %h expected %h", $time, got, exp);
    if (got !== exp)
      bad_count++;
  endtask

  task automatic cmp_cycles(input int got, input int exp);
    checked++;
    if (got != exp)
      fail($sformatf("span %0d expected %0d", got, exp));
  endtask

  // Request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int t = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20)
      fail("no pready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp_word(rd & m, exp);
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Synchroniser needs a few cycles before the timer reacts
  task automatic set_ers(input logic v);
    @(posedge sys_clk);
    external_reset_signal <= v;
    settle(6);
  endtask

  task automatic wait_pin(input logic v);
    int t = 0;
    while (pwm_output_pin !== v && t < 2000)
    begin
      @(posedge sys_clk);
      t++;
    end
    if (t >= 2000)
      fail("pin level timeout");
  endtask

  task automatic pulse(output int h);
    wait_pin(1'b0);
    wait_pin(1'b1);
    t0 = cyc;
    wait_pin(1'b0);
    h = cyc - t0;
  endtask

  task automatic tick_gap(output int g);
    int t = 0;
    g = 0;
    while (postscale_tick !== 1'b1 && t < 2000)
    begin
      @(posedge sys_clk);
      t++;
    end
    do
    begin
      @(posedge sys_clk);
      g++;
    end while (postscale_tick !== 1'b1 && g < 2000);
    if (t >= 2000 || g >= 2000)
      fail("no postscale tick");
  endtask

  task automatic high_in(input int w, output int h);
    h = 0;
    repeat (w)
    begin
      @(posedge sys_clk);
      if (pwm_output_pin === 1'b1)
        h++;
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    fail("watchdog");
    end_of_test();
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    rdc(A_TC, 32'hFFFF_FFFF, 32'(hlt_pkg::RST_TIMER_CONTROL));
    rdc(A_MD, 32'hFFFF_FFFF, 32'(hlt_pkg::RST_MODE));
    rdc(A_PR, 32'hFFFF_FFFF, 32'(hlt_pkg::RST_PERIOD));
    rdc(A_DU, 32'hFFFF_FFFF, 32'(hlt_pkg::RST_DUTY_PAIR));
    rdc(A_CP, 32'hFFFF_FFFF, 32'(hlt_pkg::RST_CAPTURE_PWM));
    apb(1'b0, 12'hFF0, 32'h0000_0000);
    cmp_word({rd[30:0], err}, 32'h0000_0001);
    wr(A_PR, 32'hFFFF_FF03);
    rdc(A_PR, 32'hFFFF_FFFF, 32'h0000_0003);
    $display("test registers done");

    wr(A_CP, 32'h0000_0080);
    wr(A_DU, 32'h0000_0006);
    for (int p = 0; p < 3; p++)
    begin
      wr(A_TC, 32'h0000_0000);
      wr(A_TC, 32'h0000_0080 | (p << 4));
      pulse(n);
      cmp_cycles(n, 6 << p);
      tick_gap(n);
      cmp_cycles(n, 16 << p);
    end
    wr(A_TC, 32'h0000_0000);
    wr(A_TC, 32'h0000_0082);
    tick_gap(n);
    cmp_cycles(n, 48);
    pulse(n);
    cmp_cycles(n, 6);
    wr(A_TC, 32'h0000_00A0);
    wait_pin(1'b0);
    wait_pin(1'b1);
    t0 = cyc;
    wr(A_DU, 32'h0000_0002);
    wait_pin(1'b0);
    cmp_cycles(cyc - t0, 24);
    pulse(n);
    cmp_cycles(n, 8);
    wr(A_TC, 32'h0000_0080);
    wr(A_CP, 32'h0000_0090);
    wr(A_DU, 32'h0000_0006 << hlt_pkg::DUTY_LEFT_LSB);
    pulse(n);
    pulse(n);
    cmp_cycles(n, 6);
    wr(A_DU, 32'h0000_0000);
    settle(40);
    high_in(40, n);
    cmp_cycles(n, 0);
    wr(A_CP, 32'h0000_0080);
    wr(A_DU, 32'h0000_0014);
    settle(40);
    high_in(40, n);
    cmp_cycles(n, 40);
    wr(A_TC, 32'h0000_0000);
    rdc(A_ST, 32'h0000_01FF, 32'h0000_0000);
    wr(A_CP, 32'h0000_0000);
    $display("test pwm done");

    wr(A_MD, 32'h0000_0008);
    wr(A_TC, 32'h0000_0080);
    rdc(A_ST, 32'h0000_0100, 32'h0000_0100);
    settle(40);
    rdc(A_TC, 32'h0000_00FF, 32'h0000_0000);
    rdc(A_ST, 32'h0000_01FF, 32'h0000_0000);
    wr(A_MD, 32'h0000_0009);
    set_ers(1'b1);
    wr(A_TC, 32'h0000_0080);
    settle(8);
    rdc(A_ST, 32'h0000_01FF, 32'h0000_0000);
    set_ers(1'b0);
    set_ers(1'b1);
    rdc(A_ST, 32'h0000_0100, 32'h0000_0100);
    settle(40);
    rdc(A_TC, 32'h0000_00FF, 32'h0000_0000);
    wr(A_MD, 32'h0000_0011);
    set_ers(1'b0);
    wr(A_TC, 32'h0000_0080);
    set_ers(1'b1);
    settle(40);
    rdc(A_TC, 32'h0000_00FF, 32'h0000_0080);
    rdc(A_ST, 32'h0000_01FF, 32'h0000_0000);
    set_ers(1'b0);
    set_ers(1'b1);
    rdc(A_ST, 32'h0000_0100, 32'h0000_0100);
    wr(A_TC, 32'h0000_0000);
    $display("test one-shot done");

    wr(A_MD, 32'h0000_0018);
    wr(A_TC, 32'h0000_0080);
    settle(20);
    rdc(A_ST, 32'h0000_01FF, 32'h0000_0000);
    wr(A_TC, 32'h0000_0000);
    wr(A_MD, 32'h0000_0001);
    set_ers(1'b0);
    wr(A_TC, 32'h0000_0080);
    rdc(A_ST, 32'h0000_01FF, 32'h0000_0100);
    settle(20);
    rdc(A_ST, 32'h0000_00FF, 32'h0000_0000);
    set_ers(1'b1);
    tick_gap(n);
    cmp_cycles(n, 16);
    wr(A_TC, 32'h0000_0000);
    wr(A_MD, 32'h0000_0007);
    wr(A_TC, 32'h0000_0080);
    settle(20);
    rdc(A_ST, 32'h0000_00FF, 32'h0000_0000);
    set_ers(1'b0);
    tick_gap(n);
    cmp_cycles(n, 16);
    wr(A_MD, 32'h0000_0000);
    rdc(A_ST, 32'h0000_0100, 32'h0000_0100);
    wr(A_TC, 32'h0000_0000);
    rdc(A_ST, 32'h0000_01FF, 32'h0000_0000);
    wr(A_MD, 32'h0000_0016);
    wr(A_TC, 32'h0000_0080);
    settle(20);
    rdc(A_ST, 32'h0000_01FF, 32'h0000_0000);
    set_ers(1'b1);
    rdc(A_ST, 32'h0000_0100, 32'h0000_0100);
    settle(40);
    rdc(A_TC, 32'h0000_00FF, 32'h0000_0000);
    $display("test free-running done");
    end_of_test();
  end

endmodule // hw_limit_timer_with_pwm_test
